// ==== include/hpsr_defs.svh ====
`ifndef HPSR_DEFS_SVH
`define HPSR_DEFS_SVH

// Register select codes on register_select_pair
`define HPSR_SEL_CTRL      2'h0
`define HPSR_SEL_DATA_INC  2'h1
`define HPSR_SEL_ADDR      2'h2
`define HPSR_SEL_DATA      2'h3

// Control register field position; reset values of the control and address registers
`define HPSR_CTRL_HWOB_BIT 0
`define HPSR_CTRL_RESET    32'h0000_0000
`define HPSR_ADDR_RESET    32'h0000_0000

// Address step for autoincrement, in bytes
`define HPSR_ADDR_STEP     32'h0000_0004

// Synchroniser depth
`define HPSR_SYNC_STAGES   2

`endif

// ==== include/hpsr_pkg.sv ====
package hpsr_pkg;

  // Access phases of the port engine
  typedef enum logic [2:0] {
    HPSR_IDLE,
    HPSR_FETCH,
    HPSR_ACTIVE,
    HPSR_STORE,
    HPSR_BUSY
  } hpsr_state_t;

  // Select signals captured at the start of an access
  typedef struct packed {
    logic [1:0] reg_sel;
    logic       rd_nwr;
    logic       half_sel;
  } hpsr_sel_t;

  // Word request to the auxiliary DMA channel
  typedef struct packed {
    logic        write;
    logic [31:0] addr;
    logic [31:0] data;
  } hpsr_dma_req_t;

endpackage

// ==== design/hpsr_sync.sv ====
`timescale 1ns/1ps
`include "hpsr_defs.svh"

// Two-flop synchroniser for a bundle of pin levels
module hpsr_sync
  import hpsr_pkg::*;
#(
  parameter int          WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      meta_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ==== design/hpsr_port.sv ====
`timescale 1ns/1ps
`include "hpsr_defs.svh"

module hpsr_port
  import hpsr_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic          port_chip_select,
  input  wire logic          port_data_strobe_one,
  input  wire logic          port_data_strobe_two,
  input  wire logic          port_addr_strobe_n,
  input  wire logic          addr_strobe_used,
  input  wire logic [1:0]    register_select_pair,
  input  wire logic          port_read_not_write,
  input  wire logic          halfword_select,
  input  wire logic [15:0]   port_data_bus_in,
  output logic      [15:0]   port_data_bus_out,
  output logic               port_data_bus_oe,
  output logic               port_wait_out,
  output logic               dma_req_valid,
  output hpsr_dma_req_t      dma_req,
  input  wire logic          dma_req_done,
  input  wire logic [31:0]   dma_rd_data,
  output logic      [31:0]   control_word,
  output logic      [31:0]   address_word
);

  // Synchronised pin levels
  logic                strobe_s;
  logic                cs_s;
  logic                as_n_s;
  logic                strobe_d_reg;
  logic                cs_d_reg;
  logic                as_d_reg;
  logic                strobe_fall;
  logic                strobe_rise;
  logic                cs_fall;
  logic                as_fall;
  logic                combined_access_strobe;
  logic [15:0]         data_s;
  hpsr_sel_t           sel_pins;
  hpsr_sel_t           sel_s;
  hpsr_sel_t           sel_reg;
  hpsr_state_t         state_reg;
  logic [31:0]         data_word_reg;
  logic [31:0]         ctrl_reg;
  logic [31:0]         addr_reg;
  logic                busy_reg;
  logic                fetch_wait_reg;
  logic                oe_reg;
  logic                wait_reg;
  // Pending work seen by a new chip select
  logic                reselect_busy_reg;
  // Address step with its carry kept apart
  logic [32:0]         addr_inc;

  // Strobe formed before synchronising so both pin strobes share one crossing
  assign combined_access_strobe = port_chip_select |
    ~(port_data_strobe_one ^ port_data_strobe_two);
  assign sel_pins = '{register_select_pair, port_read_not_write, halfword_select};

  hpsr_sync #(.WIDTH(3), .RST_VAL(3'h7)) u_sync_ctl
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({combined_access_strobe, port_chip_select, port_addr_strobe_n}),
    .sync_out ({strobe_s, cs_s, as_n_s})
  );

  // Select and data lines are held stable by the host around the strobe edges
  hpsr_sync #(.WIDTH(20), .RST_VAL(20'h0)) u_sync_dat
  (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in ({sel_pins, port_data_bus_in}),
    .sync_out ({sel_s, data_s})
  );

  // Edge detection on synchronised levels
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      strobe_d_reg <= 1'b1;
      cs_d_reg     <= 1'b1;
      as_d_reg     <= 1'b1;
    end
    else
    begin
      strobe_d_reg <= strobe_s;
      cs_d_reg     <= cs_s;
      as_d_reg     <= as_n_s;
    end
  end

  assign strobe_fall = strobe_d_reg & ~strobe_s;
  assign strobe_rise = ~strobe_d_reg & strobe_s;
  assign cs_fall     = cs_d_reg & ~cs_s;
  assign as_fall     = as_d_reg & ~as_n_s;

  // Data register access with or without autoincrement
  function automatic logic is_data(input logic [1:0] s);
    is_data = (s == `HPSR_SEL_DATA) || (s == `HPSR_SEL_DATA_INC);
  endfunction

  // Half of a 32-bit value that one host transfer carries
  function automatic logic [15:0] half_of(input logic [31:0] w, input logic hi);
    half_of = hi ? w[31:16] : w[15:0];
  endfunction

  // Addresses wrap at the top of the map; the carry is dropped on purpose
  assign addr_inc = {1'b0, addr_reg} + {1'b0, `HPSR_ADDR_STEP};

  // Select capture: address strobe fall when used, else strobe fall
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      sel_reg <= '0;
    else if (addr_strobe_used ? as_fall : strobe_fall)
      sel_reg <= sel_s;
  end

  // Access sequencer
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg      <= HPSR_IDLE;
      dma_req_valid  <= 1'b0;
      dma_req        <= '0;
      data_word_reg  <= '0;
      ctrl_reg       <= `HPSR_CTRL_RESET;
      addr_reg       <= `HPSR_ADDR_RESET;
      busy_reg       <= 1'b0;
      fetch_wait_reg <= 1'b0;
    end
    else
    begin
      dma_req_valid <= 1'b0;
      case (state_reg)
        HPSR_IDLE:
        begin
          if (strobe_fall)
          begin
            // Effective selects this cycle
            if (is_data(addr_strobe_used ? sel_reg.reg_sel : sel_s.reg_sel) &&
                (addr_strobe_used ? sel_reg.rd_nwr : sel_s.rd_nwr) &&
                !(addr_strobe_used ? sel_reg.half_sel : sel_s.half_sel))
            begin
              dma_req_valid  <= 1'b1;
              dma_req        <= '{1'b0, addr_reg, 32'h0000_0000};
              fetch_wait_reg <= 1'b1;
              state_reg      <= HPSR_FETCH;
            end
            else
              state_reg <= HPSR_ACTIVE;
          end
        end
        // Waiting for the channel to load the requested word
        HPSR_FETCH:
        begin
          if (dma_req_done)
          begin
            data_word_reg  <= dma_rd_data;
            fetch_wait_reg <= 1'b0;
            state_reg      <= HPSR_ACTIVE;
          end
        end
        // Strobe low: the host moves one half-word
        HPSR_ACTIVE:
        begin
          if (strobe_rise)
          begin
            state_reg <= HPSR_IDLE;
            if (!sel_reg.rd_nwr)
            begin
              // Write halves land in the chosen half of the word
              case (sel_reg.reg_sel)
                `HPSR_SEL_CTRL:
                  if (sel_reg.half_sel) ctrl_reg[31:16] <= data_s;
                  else ctrl_reg[15:0] <= data_s;
                `HPSR_SEL_ADDR:
                  if (sel_reg.half_sel) addr_reg[31:16] <= data_s;
                  else addr_reg[15:0] <= data_s;
                default:
                  if (sel_reg.half_sel) data_word_reg[31:16] <= data_s;
                  else data_word_reg[15:0] <= data_s;
              endcase
              if (is_data(sel_reg.reg_sel) && sel_reg.half_sel)
              begin
                dma_req_valid <= 1'b1;
                dma_req <= '{1'b1, addr_reg, {data_s, data_word_reg[15:0]}};
                busy_reg      <= 1'b1;
                state_reg     <= HPSR_STORE;
              end
            end
            else if (sel_reg.reg_sel == `HPSR_SEL_DATA_INC && sel_reg.half_sel)
            begin
              // Increment read finishes by advancing the address
              busy_reg  <= 1'b1;
              state_reg <= HPSR_BUSY;
            end
          end
        end
        // Whole word handed to the channel; ready stays busy until it lands
        HPSR_STORE:
        begin
          if (dma_req_done)
          begin
            if (sel_reg.reg_sel == `HPSR_SEL_DATA_INC)
              addr_reg <= addr_inc[31:0];
            busy_reg  <= 1'b0;
            state_reg <= HPSR_IDLE;
          end
        end
        // Increment read done; one cycle of busy covers the address step
        HPSR_BUSY:
        begin
          addr_reg  <= addr_inc[31:0];
          busy_reg  <= 1'b0;
          state_reg <= HPSR_IDLE;
        end
        default:
          state_reg <= HPSR_IDLE;
      endcase
    end
  end

  // A host that selects again before the last word is finished must see busy
  // at once, otherwise it could start a transfer on a half-updated register
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      reselect_busy_reg <= 1'b0;
    else if (!busy_reg && !fetch_wait_reg)
      reselect_busy_reg <= 1'b0;
    else if (cs_fall)
      reselect_busy_reg <= 1'b1;
  end

  // Read drive window and ready; ready only meaningful with chip select low
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oe_reg            <= 1'b0;
      port_data_bus_out <= 16'h0000;
      wait_reg          <= 1'b0;
    end
    else
    begin
      if (strobe_rise)
        oe_reg <= 1'b0;
      else if (state_reg == HPSR_ACTIVE && sel_reg.rd_nwr && !strobe_s)
        oe_reg <= 1'b1;
      // Output half follows the captured selects
      case (sel_reg.reg_sel)
        `HPSR_SEL_CTRL:
          port_data_bus_out <= half_of(ctrl_reg, sel_reg.half_sel);
        `HPSR_SEL_ADDR:
          port_data_bus_out <= half_of(addr_reg, sel_reg.half_sel);
        default:
          port_data_bus_out <= half_of(data_word_reg, sel_reg.half_sel);
      endcase
      // Busy while fetching or completing; ready drops one cycle after data
      wait_reg <= fetch_wait_reg || busy_reg || reselect_busy_reg;
    end
  end

  assign port_data_bus_oe = oe_reg & ~port_chip_select;
  assign port_wait_out    = wait_reg & ~port_chip_select;
  assign control_word     = ctrl_reg;
  assign address_word     = addr_reg;

endmodule

// ==== sim/hpsr_port_properties.sv ====
`timescale 1ns/1ps

// Watches the host pins and the outputs of the port engine
module hpsr_port_properties
  import hpsr_pkg::*;
(
  input wire logic          core_clk,
  input wire logic          sys_rst,
  input wire logic          port_chip_select,
  input wire logic          port_data_strobe_one,
  input wire logic          port_data_strobe_two,
  input wire logic [1:0]    register_select_pair,
  input wire logic          port_read_not_write,
  input wire logic          halfword_select,
  input wire logic          port_data_bus_oe,
  input wire logic          port_wait_out,
  input wire logic          dma_req_valid,
  input wire hpsr_dma_req_t dma_req,
  input wire logic          dma_req_done
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic strb;
  // Combined strobe as the host presents it
  assign strb = port_chip_select | ~(port_data_strobe_one ^ port_data_strobe_two);

  ready_cs_low_a: assert property (port_chip_select |-> !port_wait_out)
    else $error("ready high while chip select is high");
  oe_cs_gate_a: assert property (port_chip_select |-> !port_data_bus_oe)
    else $error("data bus driven while not selected");
  dma_pulse_a: assert property (dma_req_valid |=> !dma_req_valid)
    else $error("memory request longer than one cycle");
  fetch_wait_a: assert property (dma_req_valid && !dma_req.write
    |=> port_wait_out || port_chip_select)
    else $error("ready not busy during word fetch");
  done_release_a: assert property (dma_req_done |-> ##[0:2] !port_wait_out)
    else $error("ready still busy after memory transfer");
  oe_after_strobe_a: assert property ($rose(port_data_bus_oe) |-> !strb && !$past(strb))
    else $error("data bus driven before strobe fall");
  read_fetch_a: assert property ($fell(strb) && register_select_pair == 2'h3
    && port_read_not_write && !halfword_select |-> ##[2:4] dma_req_valid)
    else $error("no word fetch at first half read");
  write_store_a: assert property ($rose(strb) && register_select_pair == 2'h3
    && !port_read_not_write && halfword_select |-> ##[2:4] dma_req_valid && dma_req.write)
    else $error("no word store after second half write");
  sync_delay_a: assert property ($fell(strb) |=> !dma_req_valid)
    else $error("request issued before synchronisation");
  ctrl_no_wait_a: assert property ($fell(strb) && !register_select_pair[0]
    |-> !port_wait_out [*4])
    else $error("ready busy on control or address access");
endmodule

// ==== sim/hpsr_host_model.sv ====
`timescale 1ns/1ps

// Host processor: one half-word transfer per call of xfer
module hpsr_host_model
  import hpsr_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        port_wait_out,
  input  wire logic [15:0] bus_level,
  output logic             port_chip_select,
  output logic             port_data_strobe_one,
  output logic             port_data_strobe_two,
  output hpsr_sel_t        sel_pins,
  output logic [15:0]      host_data
);
  initial
  begin
    port_chip_select     = 1'b1;
    port_data_strobe_one = 1'b1;
    port_data_strobe_two = 1'b1;
    sel_pins             = '0;
    host_data            = 16'h0000;
  end

  // Strobe goes low through the first data strobe; the second stays high
  task automatic xfer(input hpsr_sel_t s, input logic [15:0] wd, output logic [15:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    port_chip_select <= 1'b0;
    sel_pins         <= s;
    host_data        <= wd;
    @(posedge core_clk);
    port_data_strobe_one <= 1'b0;
    repeat (6) @(posedge core_clk);
    while (port_wait_out !== 1'b0 && n < 200)
    begin
      @(posedge core_clk);
      n++;
    end
    rd = bus_level;
    port_data_strobe_one <= 1'b1;
    // Data held one cycle past strobe rise to meet its hold time
    @(posedge core_clk);
    port_chip_select <= 1'b1;
    host_data        <= ~wd; // Released bus shows no stale value
    repeat (8) @(posedge core_clk);
  endtask
endmodule

// ==== sim/host_port_strobe_ready_logic_tb.sv ====
`timescale 1ns/1ps

module host_port_strobe_ready_logic_tb;
  import hpsr_pkg::*;
  typedef struct { hpsr_sel_t s; logic [15:0] w; logic [15:0] e; } hpsr_row_t;
  logic          core_clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          cs, ds1, ds2, doe, wait_o, dv, ddone;
  hpsr_sel_t     sel_pins;
  hpsr_dma_req_t dreq, held;
  logic [15:0]   hd, dout, bus, rd;
  logic [31:0]   drd = 32'h0, cw, aw;
  logic [31:0]   mem [logic [31:0]];
  int            dly = 2, dcnt = 0, error_cnt = 0, n_compared = 0;
  hpsr_row_t     rows [10] = '{
    '{'{2'h0, 1'b0, 1'b0}, 16'h0001, 16'h0}, '{'{2'h0, 1'b0, 1'b1}, 16'h0000, 16'h0},
    '{'{2'h2, 1'b0, 1'b0}, 16'h0010, 16'h0}, '{'{2'h2, 1'b0, 1'b1}, 16'h0000, 16'h0},
    '{'{2'h3, 1'b0, 1'b0}, 16'hBEEF, 16'h0}, '{'{2'h3, 1'b0, 1'b1}, 16'hCAFE, 16'h0},
    '{'{2'h3, 1'b1, 1'b0}, 16'h0000, 16'hBEEF}, '{'{2'h3, 1'b1, 1'b1}, 16'h0000, 16'hCAFE},
    '{'{2'h1, 1'b1, 1'b0}, 16'h0000, 16'hBEEF}, '{'{2'h1, 1'b1, 1'b1}, 16'h0000, 16'hCAFE}};

  always #4 core_clk = ~core_clk;
  // Resolved level of the shared data bus
  assign bus = doe ? dout : hd;

  hpsr_host_model i_host (.core_clk(core_clk), .port_wait_out(wait_o), .bus_level(bus),
    .port_chip_select(cs), .port_data_strobe_one(ds1), .port_data_strobe_two(ds2),
    .sel_pins(sel_pins), .host_data(hd));

  hpsr_port i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .port_chip_select(cs),
    .port_data_strobe_one(ds1), .port_data_strobe_two(ds2), .port_addr_strobe_n(1'b1),
    .addr_strobe_used(1'b0), .register_select_pair(sel_pins.reg_sel),
    .port_read_not_write(sel_pins.rd_nwr), .halfword_select(sel_pins.half_sel),
    .port_data_bus_in(bus), .port_data_bus_out(dout), .port_data_bus_oe(doe),
    .port_wait_out(wait_o), .dma_req_valid(dv), .dma_req(dreq), .dma_req_done(ddone),
    .dma_rd_data(drd), .control_word(cw), .address_word(aw));

  // Memory channel answers after dly cycles; read data is junk outside done
  always @(posedge core_clk)
  begin
    ddone <= 1'b0;
    drd   <= ~drd;
    dcnt  <= sys_rst ? 0 : (dv ? dly : (dcnt > 0 ? dcnt - 1 : 0));
    if (dv)
      held <= dreq;
    if (dcnt == 1 && !dv)
    begin
      ddone <= 1'b1;
      drd   <= mem.exists(held.addr) ? mem[held.addr] : 32'h0;
      if (held.write)
        mem[held.addr] = held.data;
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      error_cnt++;
    end
  endtask

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a tenth of this
  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge core_clk);
    sys_rst <= 1'b0;
    foreach (rows[i])
    begin
      i_host.xfer(rows[i].s, rows[i].w, rd);
      if (rows[i].s.rd_nwr)
        check("read half", {16'h0, rd}, {16'h0, rows[i].e});
    end
    check("address word", aw, 32'h0000_0014);
    check("stored word", mem[32'h10], 32'hCAFE_BEEF);
    check("control word", cw, 32'h0000_0001);
    // Slow memory channel: ready must stand until the word arrives
    mem[32'h14] = 32'h5A5A_A5A5;
    dly = 30;
    i_host.xfer('{2'h3, 1'b1, 1'b0}, 16'h0000, rd);
    check("slow read", {16'h0, rd}, 32'h0000_A5A5);
    // Reset in mid-run clears the engine
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    check("reset ready", {31'h0, wait_o}, 32'h0);
    check("reset address", aw, 32'h0);
    sys_rst <= 1'b0;
    report_and_stop();
  end
endmodule

bind hpsr_port hpsr_port_properties i_props (.core_clk(core_clk), .sys_rst(sys_rst),
  .port_chip_select(port_chip_select), .port_data_strobe_one(port_data_strobe_one),
  .port_data_strobe_two(port_data_strobe_two), .register_select_pair(register_select_pair),
  .port_read_not_write(port_read_not_write), .halfword_select(halfword_select),
  .port_data_bus_oe(port_data_bus_oe), .port_wait_out(port_wait_out),
  .dma_req_valid(dma_req_valid), .dma_req(dma_req), .dma_req_done(dma_req_done));
